// ===== rtl/hiz_guard_pkg.sv
// constants, types and register map of the output high-impedance guard
//
// Overview of operation
// - any detected request input forces all six high-current pins to high impedance
// - a detected request can also raise an interrupt
// - oscillator stop or standby forces the pins to high impedance regardless of selection
// - each input selects falling edge or 16 low samples at clock/8, /16 or /128
// - pairs 3B/3D, 4A/4C, 4B/4D both low for longer than one cycle force high impedance
// - interrupts come from both input detection and output comparison
// - detection sets request flags at bits 15..12, modes at bit pairs 7:0
// - a flag clears only by writing 0 after reading it as 1; writing 1 ignored
// - input control/status register is 16 bits holding modes, enable and flags
// - output control/status register enables comparison and its interrupt separately
// - mode 00 edge, 01 clk/8, 10 clk/16, 11 clk/128; all samples must be low
// - input interrupt enable at bit 8 gates interrupt from any request flag
// - short flag bit 15 set on pair low; while set pins stay high impedance
package hiz_guard_pkg;
  localparam logic [11:0] icsr_addr = 12'h000;
  localparam logic [11:0] output_level_control_status_addr = 12'h004;
  localparam logic [11:0] irq_stat_addr = 12'h008;
  localparam logic [11:0] irq_mask_addr = 12'h00c;
  localparam int flag_lsb = 12;
  localparam int ie_bit = 8;
  localparam int osf_bit = 15;
  localparam int ocmp_en_bit = 9;
  localparam int oie_bit = 8;
  localparam int sample_count = 16;
  localparam logic [15:0] icsr_reset = 16'h0000;
  localparam logic [15:0] output_level_control_status_reset = 16'h0000;
  localparam logic [1:0] irq_mask_reset = 2'b11;
  localparam logic [6:0] div8_last = 7'd7;
  localparam logic [6:0] div16_last = 7'd15;
  localparam logic [6:0] div128_last = 7'd127;
  typedef enum logic [1:0] {
    mode_edge = 2'b00,
    mode_div8 = 2'b01,
    mode_div16 = 2'b10,
    mode_div128 = 2'b11
  } detect_mode_type;
  typedef struct packed {
    logic ch3_out_b;
    logic ch3_out_d;
    logic ch4_out_a;
    logic ch4_out_b;
    logic ch4_out_c;
    logic ch4_out_d;
  } pin_levels_type;
endpackage : hiz_guard_pkg

// ===== rtl/output_hiz_guard.sv
// output high-impedance guard with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module output_hiz_guard
  import hiz_guard_pkg::*;
#(
  parameter int n_inputs = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [n_inputs-1:0] hiz_request_inputs_n,
  input wire pin_levels_type pin_levels,
  input wire logic osc_stopped,
  input wire logic standby,
  output logic pins_hiz,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // bus data phase capture
  logic wr_pend_r;
  logic [11:0] addr_r;
  logic [3:0] flag_r;
  logic [3:0] flag_seen_r;
  logic [7:0] mode_r;
  logic ie_r;
  logic osf_r;
  logic osf_seen_r;
  logic ocmp_en_r;
  logic oie_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  logic [15:0] icsr_view;
  logic [15:0] output_level_control_status_view;
  logic addr_ok;

  assign addr_ok = hsel && hready && htrans[1];
  // zero wait states: every transfer completes in one data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 12'h000;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) begin
        addr_r <= haddr;
      end
    end
  end

  // reserved bits read as zero
  assign icsr_view = {flag_r, 3'b000, ie_r, mode_r};
  assign output_level_control_status_view = {osf_r, 5'b00000, ocmp_en_r, oie_r, 8'h00};

  // read data registered in the address phase; zero-wait answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      case (haddr)
        icsr_addr: hrdata <= {16'h0000, icsr_view};
        output_level_control_status_addr: hrdata <= {16'h0000, output_level_control_status_view};
        irq_stat_addr: hrdata <= {30'h0000_0000, stat_r};
        irq_mask_addr: hrdata <= {30'h0000_0000, mask_r};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode, shared by the read strobes and the write strobes
  function automatic logic [3:0] reg_hit(input logic [11:0] a);
    reg_hit = 4'b0000;
    case (a)
      icsr_addr: reg_hit = 4'b0001;
      output_level_control_status_addr: reg_hit = 4'b0010;
      irq_stat_addr: reg_hit = 4'b0100;
      irq_mask_addr: reg_hit = 4'b1000;
      default: reg_hit = 4'b0000;
    endcase
  endfunction : reg_hit

  logic [3:0] rd_hit;
  logic [3:0] wr_hit;
  // writes land in the data phase, so their decode uses the captured address
  assign rd_hit = (addr_ok && !hwrite) ? reg_hit(haddr) : 4'b0000;
  assign wr_hit = wr_pend_r ? reg_hit(addr_r) : 4'b0000;

  wire rd_icsr = rd_hit[0];
  wire rd_output_level_control_status = rd_hit[1];
  wire rd_stat = rd_hit[2];
  wire wr_icsr = wr_hit[0];
  wire wr_output_level_control_status = wr_hit[1];
  wire wr_mask = wr_hit[3];

  ////////////////////////////////////////////////////////////////////////////
  // control fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= icsr_reset[7:0];
      ie_r <= icsr_reset[ie_bit];
      ocmp_en_r <= output_level_control_status_reset[ocmp_en_bit];
      oie_r <= output_level_control_status_reset[oie_bit];
      mask_r <= irq_mask_reset;
    end else begin
      if (wr_icsr) begin
        // limitation: a change between clock-divided modes keeps the running low count
        mode_r <= hwdata[7:0];
        ie_r <= hwdata[ie_bit];
      end
      if (wr_output_level_control_status) begin
        ocmp_en_r <= hwdata[ocmp_en_bit];
        oie_r <= hwdata[oie_bit];
      end
      if (wr_mask) begin
        mask_r <= hwdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input request synchroniser and prescaler
  logic [n_inputs-1:0] sync1_r;
  logic [n_inputs-1:0] sync2_r;
  logic [n_inputs-1:0] prev_r;
  logic [6:0] presc_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // idle high, so a line already low at release still gives one edge
      sync1_r <= '1;
      sync2_r <= '1;
      prev_r <= '1;
    end else begin
      sync1_r <= hiz_request_inputs_n;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_r <= 7'd0;
    end else begin
      presc_r <= presc_r + 7'd1;
    end
  end

  // sample tick for a mode; the free-running prescaler keeps channels aligned
  function automatic logic tick_for(input logic [1:0] m, input logic [6:0] p);
    case (detect_mode_type'(m))
      mode_div8: tick_for = (p[2:0] == div8_last[2:0]);
      mode_div16: tick_for = (p[3:0] == div16_last[3:0]);
      mode_div128: tick_for = (p == div128_last);
      default: tick_for = 1'b0;
    endcase
  endfunction : tick_for

  ////////////////////////////////////////////////////////////////////////////
  // per-input detection
  logic [4:0] low_cnt_r [n_inputs];
  logic [n_inputs-1:0] detect;

  for (genvar i = 0; i < n_inputs; i++) begin : g_det
    wire [1:0] m = mode_r[2*i+1:2*i];
    wire tick = tick_for(m, presc_r);
    wire fell = prev_r[i] && !sync2_r[i];
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        low_cnt_r[i] <= 5'd0;
      end else if (m == mode_edge) begin
        low_cnt_r[i] <= 5'd0;
      end else if (tick) begin
        // any high sample restarts the run of 16
        if (sync2_r[i]) begin
          low_cnt_r[i] <= 5'd0;
        end else if (low_cnt_r[i] != 5'(sample_count)) begin
          low_cnt_r[i] <= low_cnt_r[i] + 5'd1;
        end
      end
    end
    assign detect[i] = (m == mode_edge) ? fell
                     : (tick && !sync2_r[i] && low_cnt_r[i] == 5'(sample_count - 1));
  end

  ////////////////////////////////////////////////////////////////////////////
  // request flags: read-1 arms, write-0 clears, set wins
  // clear needs an armed flag and a 0 written; a 1 written never clears
  function automatic logic clear_ok(input logic wr, input logic armed, input logic wbit);
    clear_ok = wr && armed && !wbit;
  endfunction : clear_ok

  // a read that sees 1 arms; any other write of the register disarms
  function automatic logic arm_next(input logic rd, input logic wr, input logic flag,
                                    input logic armed);
    if (rd && flag) begin
      arm_next = 1'b1;
    end else if (wr) begin
      arm_next = 1'b0;
    end else begin
      arm_next = armed;
    end
  endfunction : arm_next

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= icsr_reset[15:12];
      flag_seen_r <= 4'h0;
    end else begin
      for (int i = 0; i < n_inputs; i++) begin
        if (detect[i]) begin
          flag_r[i] <= 1'b1;
        end else if (clear_ok(wr_icsr, flag_seen_r[i], hwdata[flag_lsb+i])) begin
          flag_r[i] <= 1'b0;
        end
        flag_seen_r[i] <= arm_next(rd_icsr, wr_icsr, flag_r[i], flag_seen_r[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pair comparison
  logic [2:0] both_low_r;
  logic pair_3bd_low;
  logic pair_4ac_low;
  logic pair_4bd_low;
  assign pair_3bd_low = !pin_levels.ch3_out_b && !pin_levels.ch3_out_d;
  assign pair_4ac_low = !pin_levels.ch4_out_a && !pin_levels.ch4_out_c;
  assign pair_4bd_low = !pin_levels.ch4_out_b && !pin_levels.ch4_out_d;
  wire [2:0] both_low = {pair_3bd_low, pair_4ac_low, pair_4bd_low};
  // a one-cycle overlap is normal switching and must not trip the guard
  // low on two consecutive edges means longer than one cycle
  wire short_detect = ocmp_en_r && |(both_low & both_low_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      both_low_r <= 3'b000;
      osf_r <= output_level_control_status_reset[osf_bit];
      osf_seen_r <= 1'b0;
    end else begin
      both_low_r <= both_low;
      if (short_detect) begin
        osf_r <= 1'b1;
      end else if (clear_ok(wr_output_level_control_status, osf_seen_r, hwdata[osf_bit])) begin
        osf_r <= 1'b0;
      end
      osf_seen_r <= arm_next(rd_output_level_control_status, wr_output_level_control_status, osf_r, osf_seen_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin forcing and interrupts
  // combinational so the pins let go the instant the cause is gone
  logic input_hold;
  logic output_hold;
  logic supply_hold;
  assign input_hold = |flag_r;
  assign output_hold = osf_r;
  assign supply_hold = osc_stopped || standby;
  assign pins_hiz = input_hold || output_hold || supply_hold;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources
  wire in_evt = |detect;
  wire out_evt = short_detect;
  logic [1:0] stat_nxt;
  // a read that clears in the same cycle as an event keeps the event
  always_comb begin
    stat_nxt = rd_stat ? 2'b00 : stat_r;
    stat_nxt = stat_nxt | {out_evt, in_evt};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= 2'b00;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  logic irq_in;
  logic irq_out;
  logic irq_evt;
  assign irq_in = ie_r && input_hold;
  assign irq_out = oie_r && output_hold;
  assign irq_evt = |(stat_r & ~mask_r);
  assign irq = irq_in || irq_out || irq_evt;
endmodule : output_hiz_guard
`default_nettype wire

// ===== tb/fault_source_model.sv
// far side: fault request sources and gate-driver pin levels
`timescale 1ns/1ps
`default_nettype none
module fault_source_model
  import hiz_guard_pkg::*;
(
  input wire logic [3:0] req_low,
  input wire logic [2:0] pair_low,
  output logic [3:0] hiz_request_inputs_n,
  output var pin_levels_type pin_levels
);
  // released request lines sit high, as if pulled up
  assign hiz_request_inputs_n = ~req_low;
  // pairs idle complementary; a fault pulls the high side low too
  assign pin_levels = {~pair_low[0], 1'b0, ~pair_low[1], ~pair_low[2], 1'b0, 1'b0};
endmodule : fault_source_model
`default_nettype wire

// ===== tb/hiz_guard_sva.sv
// port checker for the output high-impedance guard
`timescale 1ns/1ps
`default_nettype none
module hiz_guard_sva
  import hiz_guard_pkg::*;
#(
  parameter int n_inputs = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [n_inputs-1:0] hiz_request_inputs_n,
  input wire pin_levels_type pin_levels,
  input wire logic osc_stopped,
  input wire logic standby,
  input wire logic pins_hiz,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic taken, pair_low, wr_dp_r, wrote_r;
  assign taken = hsel && hready && htrans[1];
  assign pair_low = (!pin_levels.ch3_out_b && !pin_levels.ch3_out_d)
    || (!pin_levels.ch4_out_a && !pin_levels.ch4_out_c)
    || (!pin_levels.ch4_out_b && !pin_levels.ch4_out_d);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_r <= 1'b0;
      wrote_r <= 1'b0;
    end else begin
      wr_dp_r <= taken && hwrite;
      wrote_r <= wrote_r || (taken && hwrite);
    end
  end
  ////////////////////////////////////////////////////////////
  chk_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not zero-wait okay");
  chk_stop_hiz: assert property (osc_stopped || standby |-> pins_hiz)
    else $error("pins driven in stop or standby");
  chk_hiz_cause: assert property ($rose(pins_hiz) |-> osc_stopped || standby
    || $past(pair_low) || $past(~&hiz_request_inputs_n, 3))
    else $error("high impedance without a cause");
  chk_hiz_release: assert property ($fell(pins_hiz) |-> $past(wr_dp_r)
    || $past(osc_stopped || standby))
    else $error("high impedance dropped without a clear");
  chk_irq_quiet: assert property (!wrote_r |-> !irq)
    else $error("interrupt before any enable");
  chk_rdata_hold: assert property ($changed(hrdata) |-> $past(taken && !hwrite))
    else $error("read data moved without a read");
  chk_sync_delay: assert property ($fell(hiz_request_inputs_n[0]) && !pins_hiz
    && !pair_low |=> !pins_hiz)
    else $error("request acted before synchronising");
  chk_short_debounce: assert property (pair_low && !$past(pair_low) && !pins_hiz
    && &hiz_request_inputs_n && $past(&hiz_request_inputs_n) |=> !pins_hiz)
    else $error("one-cycle overlap forced high impedance");
endmodule : hiz_guard_sva
`default_nettype wire

// ===== tb/tb_output_hiz_guard.sv
// self-checking bench for the output high-impedance guard
`timescale 1ns/1ps
`default_nettype none
module tb_output_hiz_guard
  import hiz_guard_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic osc_stopped = 1'b0;
  logic standby = 1'b0;
  logic [3:0] req_low = 4'h0;
  logic [2:0] pair_low = 3'h0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, pins_hiz, irq;
  logic [3:0] req_n;
  pin_levels_type pins;
  int errors = 0;
  int tests_run = 0;
  always #12.5 hclk = ~hclk;
  fault_source_model src (.req_low(req_low), .pair_low(pair_low),
    .hiz_request_inputs_n(req_n), .pin_levels(pins));
  output_hiz_guard #(.n_inputs(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .hiz_request_inputs_n(req_n), .pin_levels(pins), .osc_stopped(osc_stopped),
    .standby(standby), .pins_hiz(pins_hiz), .irq(irq));
  ////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : tick
  // bounded wait: a stuck bus ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      errors++;
      give_verdict();
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : bus
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, icsr_addr, 32'h0000_0000);
    chk("icsr", 32'h0000_0000, q);
    bus(1'b0, output_level_control_status_addr, 32'h0000_0000);
    chk("output_level_control_status", 32'h0000_0000, q);
    bus(1'b0, irq_mask_addr, 32'h0000_0000);
    chk("mask", 32'h0000_0003, q);
    bus(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
    // input i gets mode i, so every encoding is exercised
    bus(1'b1, icsr_addr, 32'h0000_01e4);
    for (int i = 0; i < 4; i++) begin
      int dv;
      dv = (i == 1) ? 8 : (i == 2) ? 16 : 128;
      @(posedge hclk);
      req_low <= 4'(1 << i);
      tick(i == 0 ? 2 : 15 * dv);
      chk("hiz early", 1'b0, pins_hiz);
      tick(i == 0 ? 2 : dv + 4);
      chk("hiz", 1'b1, pins_hiz);
      chk("irq", 1'b1, irq);
      @(posedge hclk);
      req_low <= 4'h0;
      bus(1'b1, icsr_addr, 32'h0000_f1e4 & ~(32'h0000_1000 << i));
      bus(1'b0, icsr_addr, 32'h0000_0000);
      chk("flag", 32'h0000_01e4 | (32'h0000_1000 << i), q);
      bus(1'b1, icsr_addr, 32'h0000_01e4);
      tick(1);
      chk("released", 1'b0, pins_hiz);
      chk("irq off", 1'b0, irq);
    end
    bus(1'b1, output_level_control_status_addr, 32'h0000_0200);
    bus(1'b1, irq_mask_addr, 32'h0000_0001);
    bus(1'b0, irq_mask_addr, 32'h0000_0000);
    chk("mask set", 32'h0000_0001, q);
    bus(1'b0, irq_stat_addr, 32'h0000_0000);
    chk("stat in", 32'h0000_0001, q);
    for (int p = 0; p < 3; p++) begin
      @(posedge hclk);
      pair_low <= 3'(1 << p);
      @(posedge hclk);
      pair_low <= 3'h0;
      tick(3);
      chk("glitch", 1'b0, pins_hiz);
      @(posedge hclk);
      pair_low <= 3'(1 << p);
      tick(3);
      chk("short", 1'b1, pins_hiz);
      chk("short irq", 1'b1, irq);
      @(posedge hclk);
      pair_low <= 3'h0;
      bus(1'b0, irq_stat_addr, 32'h0000_0000);
      chk("stat", 32'h0000_0002, q);
      bus(1'b0, output_level_control_status_addr, 32'h0000_0000);
      chk("output_level_control_status", 32'h0000_8200, q);
      bus(1'b1, output_level_control_status_addr, 32'h0000_0200);
      tick(1);
      chk("unshort", 1'b0, pins_hiz);
      chk("irq clear", 1'b0, irq);
    end
    for (int s = 1; s < 3; s++) begin
      @(posedge hclk);
      {osc_stopped, standby} <= 2'(s);
      tick(1);
      chk("stop hiz", 1'b1, pins_hiz);
      @(posedge hclk);
      {osc_stopped, standby} <= 2'b00;
      tick(1);
      chk("stop end", 1'b0, pins_hiz);
    end
    give_verdict();
  end
endmodule : tb_output_hiz_guard
bind output_hiz_guard hiz_guard_sva #(.n_inputs(n_inputs)) sva (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .hiz_request_inputs_n(hiz_request_inputs_n), .pin_levels(pin_levels),
  .osc_stopped(osc_stopped), .standby(standby), .pins_hiz(pins_hiz), .irq(irq));
`default_nettype wire
